// ==== design/esa_params.svh ====
// register offsets, field positions, reset values and channel indices of the error aggregator
`ifndef ESA_PARAMS_SVH
`define ESA_PARAMS_SVH

// ******************************
// register byte offsets
// ******************************
`define ESA_G1_IEN_LO   12'h000
`define ESA_G1_IEN_HI   12'h004
`define ESA_G1_PRIO_LO  12'h008
`define ESA_G1_PRIO_HI  12'h00C
`define ESA_G1_PIN_LO   12'h010
`define ESA_G1_PIN_HI   12'h014
`define ESA_G1_STAT_LO  12'h018
`define ESA_G1_STAT_HI  12'h01C
`define ESA_G2_STAT     12'h020
`define ESA_G3_STAT     12'h024
`define ESA_TIMEBASE    12'h028
`define ESA_FORCE       12'h02C
`define ESA_PIN_STAT    12'h030

// ******************************
// field positions and reset values
// ******************************
`define ESA_TB_PRE_LSB  0
`define ESA_TB_LOW_LSB  16
`define ESA_TB_RESET    32'h0010_0003
`define ESA_FORCE_BIT   0
`define ESA_ZERO32      32'h0000_0000

// ******************************
// channels in use per group
// ******************************
`define ESA_G1_USED     64'h4000_0FF8_DDEE_AFEE
`define ESA_G2_USED     32'h0101_1554
`define ESA_G3_USED     32'h0000_00AA
`define ESA_G1_EFUSE    40
`define ESA_G1_EFUSE_ST 41

`endif

// ==== design/esa_pkg.sv ====
// types shared by the error aggregator
package esa_pkg;
	// error pin sequence, gray coded along idle -> low -> wait; wait -> idle flips both bits
	typedef enum logic [1:0] {
		PIN_IDLE = 2'b00,
		PIN_LOW  = 2'b01,
		PIN_WAIT = 2'b11
	} esa_pin_state_type;
endpackage

// ==== design/esa_error_aggregator.sv ====
// error aggregator: three severity groups, interrupts, error pin, apb registers
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`include "esa_params.svh"

module esa_error_aggregator #(
	parameter int FUSE_W = 8
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// error sources
	input  wire logic [63:0]        g1_src,
	input  wire logic [31:0]        g2_src,
	input  wire logic [31:0]        g3_src,
	input  wire logic [FUSE_W-1:0]  fuse_err_status,
	// interrupts and error pin
	output logic                    irq_low,
	output logic                    irq_high,
	output logic                    nmi,
	output logic                    error_out_n
);

	// ******************************
	// elaboration checks
	// ******************************
	// channels that the mapping names; a used mask must keep every one of them live
	localparam logic [63:0] G1_NAMED = 64'h0000_07D8_1400_2C2C;
	localparam logic [31:0] G2_NAMED = 32'h0101_1554;
	localparam logic [31:0] G3_NAMED = 32'h0000_00AA;

	if (FUSE_W < 1 || FUSE_W > 32) begin
		$error("FUSE_W must be 1 to 32");
	end
	if ((`ESA_G1_USED & G1_NAMED) != G1_NAMED) begin
		$error("group one used mask drops a mapped channel");
	end
	if ((`ESA_G2_USED & G2_NAMED) != G2_NAMED) begin
		$error("group two used mask drops a mapped channel");
	end
	if ((`ESA_G3_USED & G3_NAMED) != G3_NAMED) begin
		$error("group three used mask drops a mapped channel");
	end
	if (`ESA_G1_EFUSE > 63 || `ESA_G1_EFUSE_ST > 63) begin
		$error("fuse channels lie outside group one");
	end
	if (`ESA_G1_EFUSE == `ESA_G1_EFUSE_ST) begin
		$error("fuse channels must differ");
	end
	if (`ESA_TB_PRE_LSB > 16 || `ESA_TB_LOW_LSB > 16 || `ESA_FORCE_BIT > 31) begin
		$error("timebase or force field lies outside its register");
	end
	if (`ESA_TB_PRE_LSB + 16 > `ESA_TB_LOW_LSB && `ESA_TB_LOW_LSB + 16 > `ESA_TB_PRE_LSB) begin
		$error("timebase fields overlap");
	end

	// ******************************
	// source conditioning
	// ******************************
	logic [63:0] g1_in;
	logic [31:0] g2_in;
	logic [31:0] g3_in;
	logic        fuse_any;

	always_comb begin
		// channel positions fixed by the used masks
		g1_in = g1_src & `ESA_G1_USED;
		// the status word is summarised, so its width matters nowhere beyond here
		fuse_any = |fuse_err_status;
		g1_in[`ESA_G1_EFUSE] = g1_src[`ESA_G1_EFUSE] | fuse_any
			| g1_src[`ESA_G1_EFUSE_ST];
		g2_in = g2_src & `ESA_G2_USED;
		g3_in = g3_src & `ESA_G3_USED;
	end

	// ******************************
	// registers
	// ******************************
	logic [63:0] g1_ien_reg;
	logic [63:0] g1_ien_next;
	logic [63:0] g1_prio_reg;
	logic [63:0] g1_prio_next;
	logic [63:0] g1_pin_reg;
	logic [63:0] g1_pin_next;
	logic [63:0] g1_stat_reg;
	logic [63:0] g1_stat_next;
	logic [31:0] g2_stat_reg;
	logic [31:0] g2_stat_next;
	logic [31:0] g3_stat_reg;
	logic [31:0] g3_stat_next;
	logic [31:0] timebase_reg;
	logic [31:0] timebase_next;
	logic        force_reg;
	logic        force_next;
	logic [31:0] prdata_next;
	logic        pready_next;
	logic        pslverr_next;
	logic        wr_en;
	logic [31:0] rd_val;
	logic        hit;

	// pin timebase state, declared here for the status readback
	esa_pkg::esa_pin_state_type pin_state_reg;
	esa_pkg::esa_pin_state_type pin_state_next;
	logic [15:0] pre_cnt_reg;
	logic [15:0] pre_cnt_next;
	logic [15:0] low_cnt_reg;
	logic [15:0] low_cnt_next;
	logic        error_out_n_next;

	// ******************************
	// apb decode
	// ******************************
	always_comb begin
		hit = 1'b1;
		case (paddr)
			`ESA_G1_IEN_LO:  rd_val = g1_ien_reg[31:0];
			`ESA_G1_IEN_HI:  rd_val = g1_ien_reg[63:32];
			`ESA_G1_PRIO_LO: rd_val = g1_prio_reg[31:0];
			`ESA_G1_PRIO_HI: rd_val = g1_prio_reg[63:32];
			`ESA_G1_PIN_LO:  rd_val = g1_pin_reg[31:0];
			`ESA_G1_PIN_HI:  rd_val = g1_pin_reg[63:32];
			`ESA_G1_STAT_LO: rd_val = g1_stat_reg[31:0];
			`ESA_G1_STAT_HI: rd_val = g1_stat_reg[63:32];
			`ESA_G2_STAT:    rd_val = g2_stat_reg;
			`ESA_G3_STAT:    rd_val = g3_stat_reg;
			`ESA_TIMEBASE:   rd_val = timebase_reg;
			`ESA_FORCE:      rd_val = {31'h0000_0000, force_reg};
			`ESA_PIN_STAT:   rd_val = {low_cnt_reg, 14'h0000, pin_state_reg};
			// unmapped offsets read as zero and answer with an error
			default: begin
				rd_val = `ESA_ZERO32;
				hit = 1'b0;
			end
		endcase
	end

	// ******************************
	// apb response
	// ******************************
	// answer in the first access cycle; no wait states
	// read data is fetched at the setup edge, so the slave never stretches a transfer
	always_comb begin
		wr_en = psel & penable & pready & pwrite & ~pslverr;
		pready_next = psel & ~penable;
		prdata_next = prdata;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			prdata_next = pwrite ? `ESA_ZERO32 : rd_val;
			pslverr_next = ~hit;
		end
	end

	// ******************************
	// configuration
	// ******************************
	always_comb begin
		g1_ien_next = g1_ien_reg;
		g1_prio_next = g1_prio_reg;
		g1_pin_next = g1_pin_reg;
		timebase_next = timebase_reg;
		force_next = force_reg;
		if (wr_en) begin
			case (paddr)
				`ESA_G1_IEN_LO:  g1_ien_next[31:0] = pwdata;
				`ESA_G1_IEN_HI:  g1_ien_next[63:32] = pwdata;
				`ESA_G1_PRIO_LO: g1_prio_next[31:0] = pwdata;
				`ESA_G1_PRIO_HI: g1_prio_next[63:32] = pwdata;
				`ESA_G1_PIN_LO:  g1_pin_next[31:0] = pwdata;
				`ESA_G1_PIN_HI:  g1_pin_next[63:32] = pwdata;
				`ESA_TIMEBASE:   timebase_next = pwdata;
				`ESA_FORCE:      force_next = pwdata[`ESA_FORCE_BIT];
				default: begin
				end
			endcase
		end
	end

	// ******************************
	// status flags
	// ******************************
	always_comb begin
		// write one to clear, then hardware set so a new event wins
		g1_stat_next = g1_stat_reg;
		g2_stat_next = g2_stat_reg;
		g3_stat_next = g3_stat_reg;
		if (wr_en) begin
			case (paddr)
				`ESA_G1_STAT_LO: g1_stat_next[31:0] = g1_stat_reg[31:0] & ~pwdata;
				`ESA_G1_STAT_HI: g1_stat_next[63:32] = g1_stat_reg[63:32] & ~pwdata;
				`ESA_G2_STAT:    g2_stat_next = g2_stat_reg & ~pwdata;
				`ESA_G3_STAT:    g3_stat_next = g3_stat_reg & ~pwdata;
				default: begin
				end
			endcase
		end
		g1_stat_next = g1_stat_next | g1_in;
		g2_stat_next = g2_stat_next | g2_in;
		g3_stat_next = g3_stat_next | g3_in;
	end

	// ******************************
	// interrupt outputs
	// ******************************
	logic        irq_low_next;
	logic        irq_high_next;
	logic        nmi_next;
	logic [63:0] g1_act;

	always_comb begin
		// levels, not pulses: a line drops only when software clears the status or, for irq_low and irq_high, changes the enable or priority
		g1_act = g1_stat_reg & g1_ien_reg;
		irq_low_next = |(g1_act & ~g1_prio_reg);
		irq_high_next = |(g1_act & g1_prio_reg);
		// group two has no mask bit at all
		nmi_next = |g2_stat_reg;
	end

	// ******************************
	// error pin timebase
	// ******************************
	logic pin_cause;
	logic tick;

	always_comb begin
		// group three never reaches an interrupt, only this pin
		// force is a level, so the pin stays low for as long as software leaves it set
		pin_cause = |(g1_stat_reg & g1_pin_reg) | (|g2_stat_reg)
			| (|g3_stat_reg) | force_reg;
		// free-running prescaler: the first tick of a low phase lands 1 to PRE+1 cycles in
		tick = (pre_cnt_reg == 16'h0000);
		pre_cnt_next = tick ? timebase_reg[`ESA_TB_PRE_LSB +: 16]
			: pre_cnt_reg - 16'h0001;
		pin_state_next = pin_state_reg;
		low_cnt_next = low_cnt_reg;
		case (pin_state_reg)
			esa_pkg::PIN_IDLE: begin
				if (pin_cause) begin
					pin_state_next = esa_pkg::PIN_LOW;
					low_cnt_next = timebase_reg[`ESA_TB_LOW_LSB +: 16];
				end
			end
			esa_pkg::PIN_LOW: begin
				// minimum low time so a slow monitor cannot miss a short error
				if (tick) begin
					if (low_cnt_reg == 16'h0000) begin
						pin_state_next = esa_pkg::PIN_WAIT;
					end else begin
						low_cnt_next = low_cnt_reg - 16'h0001;
					end
				end
			end
			esa_pkg::PIN_WAIT: begin
				if (!pin_cause) begin
					pin_state_next = esa_pkg::PIN_IDLE;
				end
			end
			default: pin_state_next = esa_pkg::PIN_IDLE;
		endcase
		error_out_n_next = (pin_state_next == esa_pkg::PIN_IDLE);
	end

	// ******************************
	// state registers
	// ******************************
	// apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pready  <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// software configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g1_ien_reg   <= 64'h0000_0000_0000_0000;
			g1_prio_reg  <= 64'h0000_0000_0000_0000;
			g1_pin_reg   <= 64'h0000_0000_0000_0000;
			timebase_reg <= `ESA_TB_RESET;
			force_reg    <= 1'b0;
		end else begin
			g1_ien_reg   <= g1_ien_next;
			g1_prio_reg  <= g1_prio_next;
			g1_pin_reg   <= g1_pin_next;
			timebase_reg <= timebase_next;
			force_reg    <= force_next;
		end
	end

	// sticky status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g1_stat_reg <= 64'h0000_0000_0000_0000;
			g2_stat_reg <= 32'h0000_0000;
			g3_stat_reg <= 32'h0000_0000;
		end else begin
			g1_stat_reg <= g1_stat_next;
			g2_stat_reg <= g2_stat_next;
			g3_stat_reg <= g3_stat_next;
		end
	end

	// interrupt lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_low  <= 1'b0;
			irq_high <= 1'b0;
			nmi      <= 1'b0;
		end else begin
			irq_low  <= irq_low_next;
			irq_high <= irq_high_next;
			nmi      <= nmi_next;
		end
	end

	// error pin sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_state_reg <= esa_pkg::PIN_IDLE;
			pre_cnt_reg   <= 16'h0000;
			low_cnt_reg   <= 16'h0000;
			error_out_n   <= 1'b1;
		end else begin
			pin_state_reg <= pin_state_next;
			pre_cnt_reg   <= pre_cnt_next;
			low_cnt_reg   <= low_cnt_next;
			error_out_n   <= error_out_n_next;
		end
	end

endmodule

// ==== test/esa_error_aggregator_assertions.sv ====
// port-level concurrent checks of the error aggregator
`timescale 1ns/10ps
`include "esa_params.svh"

module esa_error_aggregator_assertions #(
	parameter int FUSE_W = 8
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// sources
	input wire logic [63:0]       g1_src,
	input wire logic [31:0]       g2_src,
	input wire logic [31:0]       g3_src,
	input wire logic [FUSE_W-1:0] fuse_err_status,
	// responses
	input wire logic              irq_low,
	input wire logic              irq_high,
	input wire logic              nmi,
	input wire logic              error_out_n
);
	// ****************************************
	// checks
	// ****************************************
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic g2_any;
	logic g3_any;
	logic wr_force;
	assign g2_any = |(g2_src & `ESA_G2_USED);
	assign g3_any = |(g3_src & `ESA_G3_USED);
	assign wr_force = psel && penable && pready && pwrite && paddr == `ESA_FORCE
		&& pwdata[`ESA_FORCE_BIT];
	rdy_timing_a: assert property (psel && !penable |=> pready)
		else $error("pready missing in first access cycle");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_with_rdy_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	refuse_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	g2_nmi_a: assert property (g2_any |-> ##[1:2] nmi)
		else $error("group two source without nmi");
	nmi_cause_a: assert property ($rose(nmi) |-> $past(g2_any, 2))
		else $error("nmi without group two source");
	g2_pin_a: assert property (g2_any |-> ##[1:4] !error_out_n)
		else $error("group two source left pin high");
	g3_pin_a: assert property (g3_any |-> ##[1:4] !error_out_n)
		else $error("group three source left pin high");
	force_pin_a: assert property (wr_force |-> ##[1:4] !error_out_n)
		else $error("forced error left pin high");
	cover property ($rose(nmi));
	cover property ($fell(error_out_n));
	cover property (pready && pslverr);
	cover property ($rose(irq_high));
endmodule

bind esa_error_aggregator esa_error_aggregator_assertions #(.FUSE_W(FUSE_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.g1_src(g1_src), .g2_src(g2_src), .g3_src(g3_src), .fuse_err_status(fuse_err_status),
	.irq_low(irq_low), .irq_high(irq_high), .nmi(nmi), .error_out_n(error_out_n)
);

// ==== test/esa_source_model.sv ====
// model of the on-chip error sources
`timescale 1ns/10ps

module esa_source_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// command: group in bits 7:6, channel in 5:0, group 3 is fuse status
	input  wire logic        fire,
	input  wire logic [7:0]  code,
	// error source levels
	output logic      [63:0] g1_src,
	output logic      [31:0] g2_src,
	output logic      [31:0] g3_src,
	output logic      [7:0]  fuse_err_status
);
	// one-cycle pulses only: a flag that merely copies its source is caught
	always_ff @(posedge pclk) begin
		g1_src <= '0;
		g2_src <= '0;
		g3_src <= '0;
		fuse_err_status <= '0;
		if (presetn && fire) begin
			case (code[7:6])
				2'd0: g1_src[code[5:0]] <= 1'b1;
				2'd1: g2_src[code[4:0]] <= 1'b1;
				2'd2: g3_src[code[4:0]] <= 1'b1;
				default: fuse_err_status[code[2:0]] <= 1'b1;
			endcase
		end
	end
endmodule

// ==== test/esa_error_aggregator_bench.sv ====
// self-checking bench of the error aggregator
`timescale 1ns/10ps
`include "esa_params.svh"

module esa_error_aggregator_bench;
	localparam int TBL = 32;
	localparam int TBP = 1;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic        fire = 0;
	logic [7:0]  code = 0;
	logic [31:0] prdata, g2_src, g3_src, rd;
	logic [63:0] g1_src, ie, pr, pe, m;
	logic [7:0]  fuse_err_status;
	logic        pready, pslverr, irq_low, irq_high, nmi, error_out_n, er, rsv, hit, lo;
	int          bad_count = 0;
	int          num_checks = 0;
	int          n, g, c, low_run = 0, last_run = 0;
	// group one, group two (+64), group three (+128), fuse (+192), reserved (+256)
	int          tbl[$] = '{2, 3, 5, 10, 11, 13, 26, 28, 35, 36, 38, 39, 40, 41, 42,
		66, 68, 70, 72, 74, 76, 80, 88, 129, 131, 133, 135, 192, 197,
		256, 260, 268, 319, 320, 351, 384, 415};

	always #5 pclk = ~pclk;
	// ****************************************
	// design and source model
	// ****************************************
	esa_error_aggregator u_esa_error_aggregator (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .g1_src(g1_src), .g2_src(g2_src),
		.g3_src(g3_src), .fuse_err_status(fuse_err_status), .irq_low(irq_low),
		.irq_high(irq_high), .nmi(nmi), .error_out_n(error_out_n));
	esa_source_model u_esa_source_model (.pclk(pclk), .presetn(presetn), .fire(fire),
		.code(code), .g1_src(g1_src), .g2_src(g2_src), .g3_src(g3_src),
		.fuse_err_status(fuse_err_status));

	always @(posedge pclk) begin
		if (error_out_n === 1'b0)
			low_run <= low_run + 1;
		else if (low_run != 0) begin
			last_run <= low_run;
			low_run <= 0;
		end
	end

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] adr(input int g, input int c);
		if (g == 1) return `ESA_G2_STAT;
		if (g == 2) return `ESA_G3_STAT;
		return (c < 32) ? `ESA_G1_STAT_LO : `ESA_G1_STAT_HI;
	endfunction

	function automatic logic [31:0] expw(input int c, input logic rsv);
		if (rsv) return 32'h0000_0000;
		if (c == 41) return 32'h0000_0300;
		return 32'h0000_0001 << (c % 32);
	endfunction

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end

	initial begin
		n = $urandom(32'hd113);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ESA_TIMEBASE, 32'h0);
		chk("timebase", 32'h0010_0003, rd);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped_err", 32'h1, er);
		chk("unmapped_data", 32'h0, rd);
		ie = {$urandom, $urandom};
		pr = {$urandom, $urandom};
		pe = {$urandom, $urandom};
		apb(1'b1, `ESA_G1_IEN_LO, ie[31:0]);
		apb(1'b1, `ESA_G1_IEN_HI, ie[63:32]);
		apb(1'b1, `ESA_G1_PRIO_LO, pr[31:0]);
		apb(1'b1, `ESA_G1_PRIO_HI, pr[63:32]);
		apb(1'b1, `ESA_G1_PIN_LO, pe[31:0]);
		apb(1'b1, `ESA_G1_PIN_HI, pe[63:32]);
		apb(1'b1, `ESA_TIMEBASE, {TBL[15:0], TBP[15:0]});
		tbl.push_back(192 + $urandom_range(7));
		repeat (12) tbl.push_back(tbl[$urandom_range(tbl.size() - 1)]);
		foreach (tbl[i]) begin
			g = tbl[i][7:6];
			c = tbl[i][5:0];
			rsv = tbl[i][8];
			code <= tbl[i][7:0];
			fire <= 1'b1;
			@(posedge pclk);
			fire <= 1'b0;
			if (g == 3) begin
				g = 0;
				c = 40;
			end
			repeat (6) @(posedge pclk);
			// the fuse self-test channel drags channel 40 along with it
			m = 64'h0000_0000_0000_0001 << c;
			if (g == 0 && c == `ESA_G1_EFUSE_ST) begin
				m[`ESA_G1_EFUSE] = 1'b1;
			end
			hit = !rsv && g == 0;
			lo = !rsv && (g != 0 || |(m & pe));
			chk("irq_low", hit && |(m & ie & ~pr), irq_low);
			chk("irq_high", hit && |(m & ie & pr), irq_high);
			chk("nmi", !rsv && g == 1, nmi);
			chk("error_out_n", !lo, error_out_n);
			apb(1'b0, adr(g, c), 32'h0);
			chk("status", expw(c, rsv), rd);
			apb(1'b1, adr(g, c), rd);
			apb(1'b0, adr(g, c), 32'h0);
			chk("cleared", 32'h0, rd);
			while (error_out_n !== 1'b1) @(posedge pclk);
			@(posedge pclk);
			if (lo)
				chk("pin_hold", 1, last_run > TBL * (TBP + 1) && last_run <= (TBL + 1) * (TBP + 1) + 3);
		end
		apb(1'b1, `ESA_FORCE, 32'h1);
		repeat (6) @(posedge pclk);
		chk("forced_pin", 32'h0, error_out_n);
		apb(1'b1, `ESA_FORCE, 32'h0);
		print_verdict();
	end
endmodule
